// *** far_access_pkg.sv ***
// constants and carrier types for the indirect extended memory window
// assumes a 32-bit axi4-lite register bus and one core clock
package far_access_pkg;

   // register indices; byte address on the bus is four times the index
   localparam logic [7:0] IDX_ADDR_A = 8'h30;
   localparam logic [7:0] IDX_ADDR_B = 8'h31;
   localparam logic [7:0] IDX_ADDR_C = 8'h32;
   localparam logic [7:0] IDX_ADDR_D = 8'h33;
   localparam logic [7:0] IDX_CONTROL = 8'h34;
   localparam logic [7:0] IDX_CONFIG = 8'h35;
   localparam logic [7:0] IDX_DATA_A = 8'h36;
   localparam logic [7:0] IDX_DATA_B = 8'h37;

   // access control register fields
   localparam int CTL_ADDR_LSB = 0;
   localparam int CTL_ADDR_MSB = 4;
   localparam int CTL_STROBE_LSB = 5;
   localparam int CTL_STROBE_MSB = 6;
   localparam int CTL_LAUNCH = 7;

   // field holding address bits 8:6 inside its byte
   localparam int MID_ADDR_LSB = 5;
   localparam int MID_ADDR_MSB = 7;

   // configuration register fields
   localparam int CFG_BIG_END = 0;
   localparam int CFG_BUSY = 1;

   localparam int WORD_ADDR_W = 26;
   localparam int DATA_W = 16;

   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [2:0] RESET_MID = 3'h0;
   localparam logic [4:0] RESET_LOW = 5'h00;
   localparam logic [1:0] RESET_STROBE = 2'h0;
   localparam logic RESET_BIT = 1'b0;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic {st_idle, st_busy} access_state_t;

   // request to the extended memory, held while mem_req is high
   typedef struct packed {
      logic [WORD_ADDR_W-1:0] addr;
      logic [1:0] strobe;
      logic [DATA_W-1:0] wdata;
   } mem_cmd_t;

endpackage

// *** far_access.sv ***
// indirect access window onto the extended memory, axi4-lite slave
// assumes memory answers each held request with a one-cycle mem_ack on aclk
`timescale 1ns/1ps

module far_access #(
   parameter int BUS_ADDR_W = 12
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [BUS_ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [BUS_ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic mem_req,
   output far_access_pkg::mem_cmd_t mem_cmd,
   input wire logic mem_ack,
   input wire logic [far_access_pkg::DATA_W-1:0] mem_rdata
);
   import far_access_pkg::*;

   // address and data fields, held independently of byte order
   logic addr_top;
   logic [7:0] addr_upper;
   logic [7:0] addr_middle;
   logic [2:0] addr_mid3;
   logic [4:0] addr_low;
   logic [1:0] strobe;
   logic launch;
   logic [7:0] data_low;
   logic [7:0] data_high;
   logic big_end;
   access_state_t state;

   // bus side holding registers
   logic aw_full;
   logic w_full;
   logic [BUS_ADDR_W-1:0] aw_addr;
   logic [7:0] w_byte;
   logic w_lane0;

   // ---------------- write channel ----------------
   wire aw_take = s_axi_awvalid & s_axi_awready;
   wire w_take = s_axi_wvalid & s_axi_wready;
   wire do_write = aw_full & w_full & ~s_axi_bvalid;

   wire [7:0] wr_index = aw_addr[9:2];
   wire wr_aligned = (aw_addr[1:0] == 2'h0);
   wire wr_high_zero = (aw_addr >> 10) == '0;
   wire wr_ok_addr = wr_aligned & wr_high_zero;

   wire wr_hit_a = wr_ok_addr & (wr_index == IDX_ADDR_A);
   wire wr_hit_b = wr_ok_addr & (wr_index == IDX_ADDR_B);
   wire wr_hit_c = wr_ok_addr & (wr_index == IDX_ADDR_C);
   wire wr_hit_d = wr_ok_addr & (wr_index == IDX_ADDR_D);
   wire wr_hit_ctl = wr_ok_addr & (wr_index == IDX_CONTROL);
   wire wr_hit_cfg = wr_ok_addr & (wr_index == IDX_CONFIG);
   wire wr_hit_da = wr_ok_addr & (wr_index == IDX_DATA_A);
   wire wr_hit_db = wr_ok_addr & (wr_index == IDX_DATA_B);
   wire wr_mapped = wr_hit_a | wr_hit_b | wr_hit_c | wr_hit_d |
      wr_hit_ctl | wr_hit_cfg | wr_hit_da | wr_hit_db;

   // settings other than the config byte order bit are frozen while an access runs, so a stray write cannot
   // corrupt the request already on its way
   wire idle = (state == st_idle);
   wire wr_en = do_write & w_lane0 & idle;

   // byte-order steering of the write side
   wire we_top = wr_en & (big_end ? wr_hit_a : wr_hit_d);
   wire we_mid3 = wr_en & (big_end ? wr_hit_d : wr_hit_a);
   wire we_upper = wr_en & (big_end ? wr_hit_b : wr_hit_c);
   wire we_middle = wr_en & (big_end ? wr_hit_c : wr_hit_b);
   wire we_ctl = wr_en & wr_hit_ctl;
   wire we_cfg = do_write & w_lane0 & wr_hit_cfg;
   wire we_dlow = wr_en & (big_end ? wr_hit_db : wr_hit_da);
   wire we_dhigh = wr_en & (big_end ? wr_hit_da : wr_hit_db);

   wire start_req = we_ctl & w_byte[CTL_LAUNCH];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         aw_full <= 1'b0;
         aw_addr <= '0;
      end else begin
         s_axi_awready <= ~aw_full & ~aw_take & ~s_axi_bvalid;
         if (aw_take) begin
            aw_full <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end else if (do_write) begin
            aw_full <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_wready <= 1'b0;
         w_full <= 1'b0;
         w_byte <= RESET_BYTE;
         w_lane0 <= 1'b0;
      end else begin
         s_axi_wready <= ~w_full & ~w_take & ~s_axi_bvalid;
         if (w_take) begin
            w_full <= 1'b1;
            w_byte <= s_axi_wdata[7:0];
            w_lane0 <= s_axi_wstrb[0];
         end else if (do_write) begin
            w_full <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ---------------- register storage ----------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         addr_top <= RESET_BIT;
         addr_upper <= RESET_BYTE;
         addr_middle <= RESET_BYTE;
         addr_mid3 <= RESET_MID;
         big_end <= RESET_BIT;
      end else begin
         if (we_top)
            addr_top <= w_byte[0];
         if (we_upper)
            addr_upper <= w_byte;
         if (we_middle)
            addr_middle <= w_byte;
         if (we_mid3)
            addr_mid3 <= w_byte[MID_ADDR_MSB:MID_ADDR_LSB];
         if (we_cfg)
            big_end <= w_byte[CFG_BIG_END];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         addr_low <= RESET_LOW;
         strobe <= RESET_STROBE;
      end else if (we_ctl) begin
         addr_low <= w_byte[CTL_ADDR_MSB:CTL_ADDR_LSB];
         strobe <= w_byte[CTL_STROBE_MSB:CTL_STROBE_LSB];
      end
   end

   // read data is caught from memory; software writes only when idle
   wire read_done = (state == st_busy) & mem_ack & (mem_cmd.strobe == 2'h0);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         data_low <= RESET_BYTE;
         data_high <= RESET_BYTE;
      end else if (read_done) begin
         data_low <= mem_rdata[7:0];
         data_high <= mem_rdata[15:8];
      end else begin
         if (we_dlow)
            data_low <= w_byte;
         if (we_dhigh)
            data_high <= w_byte;
      end
   end

   // ---------------- access engine ----------------
   // word address: bit 0 is always zero in either layout
   wire [WORD_ADDR_W-1:0] word_addr =
      {addr_top, addr_upper, addr_middle, addr_mid3, addr_low, 1'b0};
   // launch captures the settings written in the same cycle
   wire [4:0] launch_low = w_byte[CTL_ADDR_MSB:CTL_ADDR_LSB];
   wire [1:0] launch_strobe = w_byte[CTL_STROBE_MSB:CTL_STROBE_LSB];
   wire [WORD_ADDR_W-1:0] launch_addr =
      {word_addr[WORD_ADDR_W-1:6], launch_low, 1'b0};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state <= st_idle;
         launch <= 1'b0;
         mem_req <= 1'b0;
         mem_cmd <= '0;
      end else begin
         case (state)
            st_idle: begin
               if (start_req) begin
                  state <= st_busy;
                  launch <= 1'b1;
                  mem_req <= 1'b1;
                  mem_cmd.addr <= launch_addr;
                  mem_cmd.strobe <= launch_strobe;
                  mem_cmd.wdata <= {data_high, data_low};
               end
            end
            st_busy: begin
               if (mem_ack) begin
                  state <= st_idle;
                  launch <= 1'b0;
                  mem_req <= 1'b0;
               end
            end
            default: begin
               state <= st_idle;
               launch <= 1'b0;
               mem_req <= 1'b0;
            end
         endcase
      end
   end

   // ---------------- read channel ----------------
   wire ar_take = s_axi_arvalid & s_axi_arready;
   wire [7:0] rd_index = s_axi_araddr[9:2];
   wire rd_aligned = (s_axi_araddr[1:0] == 2'h0);
   wire rd_high_zero = (s_axi_araddr >> 10) == '0;
   wire rd_ok_addr = rd_aligned & rd_high_zero;

   wire [7:0] byte_top = {7'h00, addr_top};
   wire [7:0] byte_mid3 = {addr_mid3, 5'h00};
   wire [7:0] byte_ctl = {launch, strobe, addr_low};
   wire [7:0] byte_cfg = {6'h00, ~idle, big_end};

   wire [7:0] byte_a = big_end ? byte_top : byte_mid3;
   wire [7:0] byte_b = big_end ? addr_upper : addr_middle;
   wire [7:0] byte_c = big_end ? addr_middle : addr_upper;
   wire [7:0] byte_d = big_end ? byte_mid3 : byte_top;
   wire [7:0] byte_da = big_end ? data_high : data_low;
   wire [7:0] byte_db = big_end ? data_low : data_high;

   logic [7:0] rd_byte;
   logic rd_mapped;
   always_comb begin
      rd_byte = 8'h00;
      rd_mapped = rd_ok_addr;
      case (rd_index)
         IDX_ADDR_A: rd_byte = byte_a;
         IDX_ADDR_B: rd_byte = byte_b;
         IDX_ADDR_C: rd_byte = byte_c;
         IDX_ADDR_D: rd_byte = byte_d;
         IDX_CONTROL: rd_byte = byte_ctl;
         IDX_CONFIG: rd_byte = byte_cfg;
         IDX_DATA_A: rd_byte = byte_da;
         IDX_DATA_B: rd_byte = byte_db;
         default: rd_mapped = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
      end else begin
         s_axi_arready <= ~s_axi_rvalid & ~ar_take;
         if (ar_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, rd_mapped ? rd_byte : 8'h00};
            s_axi_rresp <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

endmodule // far_access

// *** far_access_monitor.sv ***
// checker for the extended memory window, sees top-level ports only
// assumes one aclk domain, bound to every far_access instance
`timescale 1ns/1ps

module far_access_monitor
   import far_access_pkg::*;
#(
   parameter int BUS_ADDR_W = 12
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [BUS_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic mem_req,
   input wire far_access_pkg::mem_cmd_t mem_cmd,
   input wire logic mem_ack
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   wire ar_go = s_axi_arvalid && s_axi_arready;
   wire [7:0] ar_idx = s_axi_araddr[9:2];
   wire ar_bad = (s_axi_araddr[1:0] != 2'h0) || (ar_idx < IDX_ADDR_A)
      || (ar_idx > IDX_DATA_B) || (s_axi_araddr[BUS_ADDR_W-1:10] != '0);

   cmd_held_a:
      assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_cmd))
         else $error("memory request dropped or changed before ack");
   req_ends_a:
      assert property (mem_req && mem_ack |=> !mem_req)
         else $error("memory request still up after ack");
   word_addr_a:
      assert property (mem_req |-> !mem_cmd.addr[0])
         else $error("word address bit 0 not zero");
   b_done_a:
      assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
         else $error("write response repeated");
   r_done_a:
      assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
         else $error("read response repeated");
   r_answer_a:
      assert property (ar_go |=> s_axi_rvalid)
         else $error("read answer late");
   bad_read_a:
      assert property (ar_go && ar_bad |=> s_axi_rresp == RESP_SLVERR
         && s_axi_rdata == 32'h0)
         else $error("unmapped read not refused");
   byte_lane_a:
      assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
         else $error("upper read data not zero");

   cover property (mem_req && mem_ack && mem_cmd.strobe == 2'h0);
   cover property (mem_req && mem_ack && mem_cmd.strobe == 2'h3);
   cover property (ar_go && ar_bad);
endmodule // far_access_monitor

bind far_access far_access_monitor #(.BUS_ADDR_W(BUS_ADDR_W)) mon (
   .aclk, .aresetn, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
   .s_axi_bvalid, .s_axi_bready, .mem_req, .mem_cmd, .mem_ack);

// *** far_mem_model.sv ***
// behavioural extended memory answering one held request at a time
// assumes requests stay up until mem_ack, all on aclk
`timescale 1ns/1ps

module far_mem_model (
   input wire logic aclk,
   input wire logic mem_req,
   input wire far_access_pkg::mem_cmd_t mem_cmd,
   input wire logic [3:0] delay,
   output logic mem_ack,
   output logic [far_access_pkg::DATA_W-1:0] mem_rdata
);
   import far_access_pkg::*;
   logic [DATA_W-1:0] mem [int];
   logic [DATA_W-1:0] word;
   int wait_cnt = 0;
   initial begin
      mem_ack = 1'b0;
      mem_rdata = 16'h5a5a;
   end
   always @(posedge aclk) begin
      mem_ack <= 1'b0;
      // toggles outside the answer so stale data never looks right
      mem_rdata <= ~mem_rdata;
      if (mem_req && !mem_ack) begin
         if (wait_cnt < delay) begin
            wait_cnt <= wait_cnt + 1;
         end else begin
            word = mem.exists(int'(mem_cmd.addr)) ? mem[int'(mem_cmd.addr)]
               : 16'h0000;
            if (mem_cmd.strobe[1]) word[15:8] = mem_cmd.wdata[15:8];
            if (mem_cmd.strobe[0]) word[7:0] = mem_cmd.wdata[7:0];
            mem[int'(mem_cmd.addr)] = word;
            mem_rdata <= word;
            mem_ack <= 1'b1;
            wait_cnt <= 0;
         end
      end
   end
endmodule // far_mem_model

// *** tb.sv ***
// self-checking bench for the extended memory window over axi4-lite
// assumes far_mem_model as the memory, 50 MHz aclk
`timescale 1ns/1ps

module tb;
   import far_access_pkg::*;
   logic aclk = 1'b0, aresetn = 1'b0;
   logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [2:0] s_axi_awprot = '0, s_axi_arprot = '0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hf, delay = 4'hc;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, mem_req, mem_ack;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [15:0] mem_rdata;
   mem_cmd_t mem_cmd, last_cmd;
   logic [7:0] hi_t[2] = '{8'h56, 8'h9a}, lo_t[2] = '{8'h78, 8'hbc};
   logic [7:0] exp_hi[2] = '{8'h34, 8'h9a};
   int fail_count = 0, checks = 0;

   always #10 aclk = ~aclk;
   always @(posedge aclk) if (mem_req && mem_ack) last_cmd <= mem_cmd;

   far_access dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .mem_req, .mem_cmd, .mem_ack, .mem_rdata);
   far_mem_model model (.aclk, .mem_req, .mem_cmd, .delay, .mem_ack,
      .mem_rdata);

   function automatic logic [11:0] ba(input logic [7:0] i);
      return {2'b00, i, 2'b00};
   endfunction
   task check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task wr(input logic [11:0] a, input logic [7:0] v,
      input logic [1:0] r = RESP_OKAY);
      logic aw_p;
      logic w_p;
      // nba updates land late, so the pending flags are tracked locally
      aw_p = 1'b1;
      w_p = 1'b1;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, v};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (aw_p || w_p) begin
         @(posedge aclk);
         if (aw_p && s_axi_awready) begin
            s_axi_awvalid <= 1'b0;
            aw_p = 1'b0;
         end
         if (w_p && s_axi_wready) begin
            s_axi_wvalid <= 1'b0;
            w_p = 1'b0;
         end
      end
      do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      check(s_axi_bresp, r);
   endtask
   task rd(input logic [11:0] a, output logic [31:0] d,
      output logic [1:0] r);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      d = s_axi_rdata;
      r = s_axi_rresp;
   endtask
   task rc(input logic [11:0] a, input logic [7:0] v,
      input logic [1:0] r = RESP_OKAY);
      logic [31:0] d;
      logic [1:0] rs;
      rd(a, d, rs);
      check(d, {24'h0, v});
      check(rs, r);
   endtask
   task wait_done;
      logic [31:0] d;
      logic [1:0] rs;
      do rd(ba(IDX_CONTROL), d, rs); while (d[7] === 1'b1);
      check(d[7], 1'b0);
   endtask
   task print_verdict;
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   initial begin
      #200us;
      fail_count++;
      print_verdict;
   end

   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      for (int i = 8'h30; i <= 8'h37; i++) rc(ba(i[7:0]), 8'h00);
      rc(ba(8'h38), 8'h00, RESP_SLVERR);
      rc(12'h0c1, 8'h00, RESP_SLVERR);
      wr(ba(8'h40), 8'h11, RESP_SLVERR);
      wr(ba(IDX_ADDR_A), 8'hff);
      rc(ba(IDX_ADDR_A), 8'he0);
      wr(ba(IDX_ADDR_D), 8'hff);
      rc(ba(IDX_ADDR_D), 8'h01);
      // lane 0 strobe low: write answered but discarded
      s_axi_wstrb <= 4'h0;
      wr(ba(IDX_ADDR_B), 8'h77);
      s_axi_wstrb <= 4'hf;
      rc(ba(IDX_ADDR_B), 8'h00);
      wr(ba(IDX_ADDR_B), 8'ha5);
      wr(ba(IDX_ADDR_C), 8'h3c);
      wr(ba(IDX_DATA_A), 8'h12);
      wr(ba(IDX_DATA_B), 8'h34);
      wr(ba(IDX_CONTROL), 8'hf5);
      rc(ba(IDX_CONTROL), 8'hf5);
      wr(ba(IDX_DATA_A), 8'hee);
      rc(ba(IDX_CONFIG), 8'h02);
      wait_done;
      check(last_cmd.addr, {1'b1, 8'h3c, 8'ha5, 3'h7, 5'h15, 1'b0});
      check(last_cmd.wdata, 16'h3412);
      rc(ba(IDX_DATA_A), 8'h12);
      delay <= 4'h0;
      // one lane at a time, each followed by a read of the same word
      for (int k = 0; k < 2; k++) begin
         wr(ba(IDX_DATA_A), lo_t[k]);
         wr(ba(IDX_DATA_B), hi_t[k]);
         wr(ba(IDX_CONTROL), {1'b1, 2'(k + 1), 5'h15});
         wait_done;
         wr(ba(IDX_CONTROL), 8'h95);
         wait_done;
         check(last_cmd.strobe, 2'h0);
         rc(ba(IDX_DATA_B), exp_hi[k]);
         rc(ba(IDX_DATA_A), 8'h78);
      end
      wr(ba(IDX_CONFIG), 8'h01);
      rc(ba(IDX_ADDR_A), 8'h01);
      rc(ba(IDX_ADDR_B), 8'h3c);
      rc(ba(IDX_ADDR_C), 8'ha5);
      rc(ba(IDX_ADDR_D), 8'he0);
      rc(ba(IDX_DATA_A), 8'h9a);
      wr(ba(IDX_DATA_A), 8'hde);
      wr(ba(IDX_DATA_B), 8'had);
      wr(ba(IDX_CONTROL), 8'hf5);
      wait_done;
      check(last_cmd.wdata, 16'hdead);
      check(last_cmd.addr, {1'b1, 8'h3c, 8'ha5, 3'h7, 5'h15, 1'b0});
      print_verdict;
   end
endmodule // tb
